// ==== testbench/carrier_phase_filter_cfg_test.sv ====
// self-checking bench for the carrier phase and filter config block
`timescale 1ns/1ps
`default_nettype none
`include "carrier_cfg_regs.svh"
module carrier_phase_filter_cfg_test
   import carrier_cfg_pkg::*;
;
   logic               sys_clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               ce = 1'b1;
   logic               input_enable_n = 1'b0;
   logic               carrier_sync_pin = 1'b0;
   logic               filter_sync_pin = 1'b0;
   logic [`ADDR_W-1:0] addr;
   logic [31:0]        wdata;
   logic [31:0]        rdata;
   logic [31:0]        rd_val;
   logic               wr;
   logic               rd;
   logic [9:0]         active_phase;
   logic [31:0]        active_freq;
   filter_cfg_s        filter_cfg;
   logic [4:0]         fir_decimation;
   logic               filter_ctrl_reset;
   cfg_status_s        status;
   int                 n_errors = 0;
   int                 num_checks = 0;

   always #2 sys_clk = ~sys_clk;

   carrier_phase_filter_cfg uut (
      .SYS_CLK           (sys_clk),
      .RST_N             (rst_n),
      .CE                (ce),
      .ADDR              (addr),
      .WDATA             (wdata),
      .WR                (wr),
      .RD                (rd),
      .RDATA             (rdata),
      .INPUT_ENABLE_N    (input_enable_n),
      .CARRIER_SYNC_PIN  (carrier_sync_pin),
      .FILTER_SYNC_PIN   (filter_sync_pin),
      .ACTIVE_PHASE      (active_phase),
      .ACTIVE_FREQ       (active_freq),
      .FILTER_CFG        (filter_cfg),
      .FIR_DECIMATION    (fir_decimation),
      .FILTER_CTRL_RESET (filter_ctrl_reset),
      .STATUS            (status)
   );

   host_model host (
      .clk   (sys_clk),
      .addr  (addr),
      .wdata (wdata),
      .wr    (wr),
      .rd    (rd),
      .rdata (rdata)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up

   task automatic test_reset();
      #1;
      check(32'(filter_cfg), 32'h00000001);
      check(32'(fir_decimation), 32'h00000001);
      check(32'(active_phase), 32'h00000000);
      check(32'(status), 32'h00000008);
      host.read_word(4'hF, rd_val);
      check(rd_val, 32'h00000000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_phase_strobe();
      host.write_word(`ADDR_PHASE_HOLD, 32'hFFFFFEAB);
      settle();
      check(32'(active_phase), 32'h00000000);
      host.read_word(`ADDR_PHASE_HOLD, rd_val);
      check(rd_val, 32'h000002AB);
      host.write_word(`ADDR_PHASE_STROBE, 32'h00000000);
      settle();
      check(32'(active_phase), 32'h000002AB);
      host.read_word(`ADDR_PHASE_STROBE, rd_val);
      check(rd_val, 32'h00000000);
      $display("test_phase_strobe done");
   endtask : test_phase_strobe

   task automatic test_pending();
      @(posedge sys_clk);
      input_enable_n <= 1'b1;
      host.write_word(`ADDR_PHASE_HOLD, 32'h00000155);
      host.write_word(`ADDR_PHASE_STROBE, 32'h00000000);
      settle();
      settle();
      check(32'(active_phase), 32'h000002AB);
      check(32'(status.phase_pending), 32'h00000001);
      check(32'(status.freq_pending), 32'h00000000);
      host.read_word(`ADDR_STATUS, rd_val);
      check(rd_val, 32'h000502AB);
      @(posedge sys_clk);
      input_enable_n <= 1'b0;
      settle();
      check(32'(active_phase), 32'h00000155);
      check(32'(status.phase_pending), 32'h00000000);
      $display("test_pending done");
   endtask : test_pending

   task automatic test_freq();
      host.write_word(`ADDR_FREQ_HOLD, 32'h12345678);
      settle();
      check(active_freq, 32'h00000000);
      host.write_word(`ADDR_FREQ_STROBE, 32'hDEADBEEF);
      settle();
      check(active_freq, 32'h12345678);
      $display("test_freq done");
   endtask : test_freq

   task automatic pulse_sync();
      @(posedge sys_clk);
      carrier_sync_pin <= 1'b1;
      @(posedge sys_clk);
      carrier_sync_pin <= 1'b0;
      settle();
   endtask : pulse_sync

   task automatic test_carrier_sync();
      host.write_word(`ADDR_PHASE_HOLD, 32'h000003C7);
      host.write_word(`ADDR_FREQ_HOLD, 32'h0BADF00D);
      pulse_sync();
      check(32'(active_phase), 32'h00000155);
      host.write_word(`ADDR_SYNC_CTRL, 32'h00100000);
      pulse_sync();
      check(32'(active_phase), 32'h000003C7);
      check(active_freq, 32'h0BADF00D);
      host.read_word(`ADDR_SYNC_CTRL, rd_val);
      check(rd_val, 32'h00100000);
      $display("test_carrier_sync done");
   endtask : test_carrier_sync

   task automatic test_freeze();
      @(posedge sys_clk);
      ce <= 1'b0;
      host.write_word(`ADDR_PHASE_HOLD, 32'h000000F0);
      host.write_word(`ADDR_PHASE_STROBE, 32'h00000000);
      @(posedge sys_clk);
      ce <= 1'b1;
      settle();
      check(32'(active_phase), 32'h000003C7);
      host.read_word(`ADDR_PHASE_HOLD, rd_val);
      check(rd_val, 32'h000003C7);
      $display("test_freeze done");
   endtask : test_freeze

   task automatic test_filter_cfg();
      host.write_word(`ADDR_FILTER_CFG, 32'hFFCA9DFF);
      settle();
      check(32'(filter_cfg), 32'h000A9DFF);
      check(32'(fir_decimation), 32'h00000003);
      check(32'(status.stage_err), 32'h00000000);
      host.read_word(`ADDR_FILTER_CFG, rd_val);
      check(rd_val, 32'h000A9DFF);
      host.write_word(`ADDR_FILTER_CFG, 32'h00150201);
      settle();
      check(32'(filter_cfg), 32'h00150201);
      check(32'(fir_decimation), 32'h00000010);
      for (int c = 1; c < 16; c++) begin
         host.write_word(`ADDR_FILTER_CFG, 32'h00100001 | (32'(c) << 11));
         settle();
         check(32'(fir_decimation), 32'(c));
      end
      $display("test_filter_cfg done");
   endtask : test_filter_cfg

   task automatic test_filter_sync();
      host.write_word(`ADDR_FILTER_CFG, 32'h00100001);
      @(posedge sys_clk);
      filter_sync_pin <= 1'b1;
      settle();
      check(32'(filter_ctrl_reset), 32'h00000000);
      host.write_word(`ADDR_FILTER_CFG, 32'h00300001);
      settle();
      check(32'(filter_ctrl_reset), 32'h00000001);
      @(posedge sys_clk);
      filter_sync_pin <= 1'b0;
      settle();
      check(32'(filter_ctrl_reset), 32'h00000000);
      $display("test_filter_sync done");
   endtask : test_filter_sync

   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      test_reset();
      test_phase_strobe();
      test_pending();
      test_freq();
      test_carrier_sync();
      test_freeze();
      test_filter_cfg();
      test_filter_sync();
      wrap_up();
   end

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_errors++;
      wrap_up();
   end
endmodule : carrier_phase_filter_cfg_test
`default_nettype wire

// ==== testbench/host_model.sv ====
// host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
`include "carrier_cfg_regs.svh"
module host_model (
   // clock
   input  wire logic               clk,
   // register port
   output var  logic [`ADDR_W-1:0] addr,
   output var  logic [31:0]        wdata,
   output var  logic               wr,
   output var  logic               rd,
   input  wire logic [31:0]        rdata
);
   initial begin
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
   end

   task automatic write_word(input logic [`ADDR_W-1:0] a,
                             input logic [31:0] d);
      // never sends a filter word with no stage and no bypass, or with zero taps
      if (a == `ADDR_FILTER_CFG && ((!d[20] && d[19:15] == 5'h00) ||
          d[7:0] == 8'h00)) begin
         return;
      end
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      wdata <= ~d;
   endtask : write_word

   task automatic read_word(input logic [`ADDR_W-1:0] a,
                            output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : read_word
endmodule : host_model
`default_nettype wire

// ==== verilog/carrier_cfg_pkg.sv ====
// types shared by the carrier phase and filter configuration block
package carrier_cfg_pkg;

   // field order matches bits 21..0 of the filter word
   typedef struct packed {
      logic       ext_sync_en;
      logic       hb_bypass;
      logic [4:0] hb_stage_en;
      logic [3:0] fir_dec_code;
      logic       fir_dual_real;
      logic       fir_even_sym;
      logic       fir_asym;
      logic [7:0] fir_taps;
   } filter_cfg_s;

   typedef struct packed {
      logic       stage_err;
      logic       taps_err;
      logic       freq_pending;
      logic       phase_pending;
   } cfg_status_s;

endpackage : carrier_cfg_pkg

// ==== verilog/carrier_cfg_regs.svh ====
// register offsets, field positions and reset values of the carrier block
`ifndef CARRIER_CFG_REGS_SVH
`define CARRIER_CFG_REGS_SVH

`define ADDR_W            4
`define ADDR_SYNC_CTRL    4'h0
`define ADDR_FREQ_HOLD    4'h3
`define ADDR_PHASE_HOLD   4'h4
`define ADDR_FREQ_STROBE  4'h5
`define ADDR_PHASE_STROBE 4'h6
`define ADDR_FILTER_CFG   4'h7
`define ADDR_STATUS       4'h8

`define SYNC_LOAD_BIT     20
`define PHASE_MSB         9
`define CFG_MSB           21
`define DEC_LSB           11
`define DEC_MSB           14
`define ST_PHASE_PEND     16
`define ST_FREQ_PEND      17
`define ST_STAGE_ERR      18
`define ST_TAPS_ERR       19

`define SYNC_CTRL_RESET   1'h0
`define PHASE_RESET       10'h000
`define FREQ_RESET        32'h00000000
`define CFG_RESET         22'h000001
`define DEC_FULL          5'h10

`endif

// ==== verilog/carrier_phase_filter_cfg.sv ====
// carrier phase/frequency transfer and filter configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "carrier_cfg_regs.svh"
module carrier_phase_filter_cfg
   import carrier_cfg_pkg::*;
#(
   parameter int PHASE_W = 10,
   parameter int FREQ_W  = 32
) (
   // clock, reset, enable
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   input  wire logic              CE,
   // register port
   input  wire logic [`ADDR_W-1:0] ADDR,
   input  wire logic [31:0]        WDATA,
   input  wire logic               WR,
   input  wire logic               RD,
   output var  logic [31:0]        RDATA,
   // pins
   input  wire logic               INPUT_ENABLE_N,
   input  wire logic               CARRIER_SYNC_PIN,
   input  wire logic               FILTER_SYNC_PIN,
   // carrier oscillator words
   output var  logic [PHASE_W-1:0] ACTIVE_PHASE,
   output var  logic [FREQ_W-1:0]  ACTIVE_FREQ,
   // filter configuration
   output var  filter_cfg_s        FILTER_CFG,
   output var  logic [4:0]         FIR_DECIMATION,
   output var  logic               FILTER_CTRL_RESET,
   output var  cfg_status_s        STATUS
);

   generate
      if (PHASE_W != `PHASE_MSB + 1 || FREQ_W > 32) begin : g_bad_param
         $error("unsupported phase or frequency width");
      end
   endgenerate

   // reset release
   logic       rst_meta;
   logic       rst_n;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // decode
   logic wr_sync_ctrl;
   logic wr_freq_hold;
   logic wr_phase_hold;
   logic wr_freq_strobe;
   logic wr_phase_strobe;
   logic wr_filter_cfg;

   assign wr_sync_ctrl    = CE && WR && (ADDR == `ADDR_SYNC_CTRL);
   assign wr_freq_hold    = CE && WR && (ADDR == `ADDR_FREQ_HOLD);
   assign wr_phase_hold   = CE && WR && (ADDR == `ADDR_PHASE_HOLD);
   assign wr_freq_strobe  = CE && WR && (ADDR == `ADDR_FREQ_STROBE);
   assign wr_phase_strobe = CE && WR && (ADDR == `ADDR_PHASE_STROBE);
   assign wr_filter_cfg   = CE && WR && (ADDR == `ADDR_FILTER_CFG);

   // sync-load enable
   logic sync_load_en;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sync_load_en <= `SYNC_CTRL_RESET;
      end else if (wr_sync_ctrl) begin
         sync_load_en <= WDATA[`SYNC_LOAD_BIT];
      end
   end

   // holding registers
   logic [PHASE_W-1:0] phase_hold;
   logic [FREQ_W-1:0]  freq_hold;

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         phase_hold <= `PHASE_RESET;
      end else if (wr_phase_hold) begin
         phase_hold <= WDATA[`PHASE_MSB:0];
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         freq_hold <= FREQ_W'(`FREQ_RESET);
      end else if (wr_freq_hold) begin
         freq_hold <= WDATA[FREQ_W-1:0];
      end
   end

   // transfer requests; strobe data is never stored
   logic sync_req;
   logic phase_req;
   logic freq_req;
   logic upd_en;

   assign sync_req  = CARRIER_SYNC_PIN && sync_load_en;
   assign phase_req = wr_phase_strobe || sync_req;
   assign freq_req  = wr_freq_strobe || sync_req;
   assign upd_en    = !INPUT_ENABLE_N;

   logic phase_pending;
   logic freq_pending;

   // phase bits pass unchanged; either encoding is the same angle mod 2pi
   transfer_latch #(
      .W (PHASE_W)
   ) u_phase_xfer (
      .clk      (SYS_CLK),
      .rst_n    (rst_n),
      .ce       (CE),
      .hold     (phase_hold),
      .load_req (phase_req),
      .upd_en   (upd_en),
      .active   (ACTIVE_PHASE),
      .pending  (phase_pending)
   );

   transfer_latch #(
      .W (FREQ_W)
   ) u_freq_xfer (
      .clk      (SYS_CLK),
      .rst_n    (rst_n),
      .ce       (CE),
      .hold     (freq_hold),
      .load_req (freq_req),
      .upd_en   (upd_en),
      .active   (ACTIVE_FREQ),
      .pending  (freq_pending)
   );

   // filter word, processing-domain logic on the one clock
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         FILTER_CFG <= filter_cfg_s'(`CFG_RESET);
      end else if (wr_filter_cfg) begin
         FILTER_CFG <= filter_cfg_s'(WDATA[`CFG_MSB:0]);
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         FIR_DECIMATION <= 5'h01;
      end else if (wr_filter_cfg) begin
         if (WDATA[`DEC_MSB:`DEC_LSB] == 4'h0) begin
            FIR_DECIMATION <= `DEC_FULL;
         end else begin
            FIR_DECIMATION <= {1'b0, WDATA[`DEC_MSB:`DEC_LSB]};
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         FILTER_CTRL_RESET <= 1'b0;
      end else if (CE) begin
         FILTER_CTRL_RESET <= FILTER_SYNC_PIN && FILTER_CFG.ext_sync_en;
      end
   end

   // status, flags host mistakes
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         STATUS <= '0;
      end else if (CE) begin
         STATUS.stage_err     <= !FILTER_CFG.hb_bypass &&
                                 (FILTER_CFG.hb_stage_en == 5'h00);
         STATUS.taps_err      <= (FILTER_CFG.fir_taps == 8'h00);
         STATUS.freq_pending  <= freq_pending;
         STATUS.phase_pending <= phase_pending;
      end
   end

   // read port, data only in the cycle after the strobe
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 32'h00000000;
      end else if (CE) begin
         RDATA <= 32'h00000000;
         if (RD) begin
            if (ADDR == `ADDR_SYNC_CTRL) begin
               RDATA[`SYNC_LOAD_BIT] <= sync_load_en;
            end else if (ADDR == `ADDR_FREQ_HOLD) begin
               RDATA[FREQ_W-1:0] <= freq_hold;
            end else if (ADDR == `ADDR_PHASE_HOLD) begin
               RDATA[`PHASE_MSB:0] <= phase_hold;
            end else if (ADDR == `ADDR_FILTER_CFG) begin
               RDATA[`CFG_MSB:0] <= FILTER_CFG;
            end else if (ADDR == `ADDR_STATUS) begin
               RDATA[`PHASE_MSB:0]     <= ACTIVE_PHASE;
               RDATA[`ST_PHASE_PEND]   <= phase_pending;
               RDATA[`ST_FREQ_PEND]    <= freq_pending;
               RDATA[`ST_STAGE_ERR]    <= STATUS.stage_err;
               RDATA[`ST_TAPS_ERR]     <= STATUS.taps_err;
            end
         end
      end
   end

   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!rst_n);

   property p_phase_strobe;
      (wr_phase_strobe && upd_en) |=>
         (ACTIVE_PHASE == $past(phase_hold));
   endproperty
   a_phase_strobe: assert property (p_phase_strobe)
      else $error("phase strobe did not load active phase");

   property p_freq_strobe;
      (wr_freq_strobe && upd_en) |=>
         (ACTIVE_FREQ == $past(freq_hold));
   endproperty
   a_freq_strobe: assert property (p_freq_strobe)
      else $error("frequency strobe did not load active word");

   property p_sync_gated;
      (CE && CARRIER_SYNC_PIN && !sync_load_en && !wr_phase_strobe
         && !phase_pending) |=> $stable(ACTIVE_PHASE);
   endproperty
   a_sync_gated: assert property (p_sync_gated)
      else $error("carrier sync loaded phase while disabled");

   property p_enable_hold;
      INPUT_ENABLE_N |=> $stable(ACTIVE_PHASE) && $stable(ACTIVE_FREQ);
   endproperty
   a_enable_hold: assert property (p_enable_hold)
      else $error("oscillator word changed while input disabled");

   property p_hold_write_only;
      (wr_phase_hold && !phase_pending && !sync_req)
         |=> $stable(ACTIVE_PHASE);
   endproperty
   a_hold_write_only: assert property (p_hold_write_only)
      else $error("holding write changed active phase");

   property p_filter_sync;
      CE |=> (FILTER_CTRL_RESET ==
              ($past(FILTER_SYNC_PIN) && $past(FILTER_CFG.ext_sync_en)));
   endproperty
   a_filter_sync: assert property (p_filter_sync)
      else $error("filter reset does not follow gated sync pin");

   property p_decimation;
      wr_filter_cfg |=> (FIR_DECIMATION ==
         (($past(WDATA[`DEC_MSB:`DEC_LSB]) == 4'h0) ? `DEC_FULL :
          {1'b0, $past(WDATA[`DEC_MSB:`DEC_LSB])}));
   endproperty
   a_decimation: assert property (p_decimation)
      else $error("decimation decode wrong");

   property p_cfg_fields;
      wr_filter_cfg |=> (FILTER_CFG.hb_stage_en == $past(WDATA[19:15]))
         && (FILTER_CFG.fir_dual_real == $past(WDATA[10]))
         && (FILTER_CFG.fir_even_sym == $past(WDATA[9]))
         && (FILTER_CFG.fir_asym == $past(WDATA[8]));
   endproperty
   a_cfg_fields: assert property (p_cfg_fields)
      else $error("filter fields not captured");

   property p_stage_err;
      (CE && !FILTER_CFG.hb_bypass && FILTER_CFG.hb_stage_en == 5'h00)
         |=> STATUS.stage_err;
   endproperty
   a_stage_err: assert property (p_stage_err)
      else $error("missing stage error flag");

   property p_taps_err;
      CE |=> (STATUS.taps_err == ($past(FILTER_CFG.fir_taps) == 8'h00));
   endproperty
   a_taps_err: assert property (p_taps_err)
      else $error("tap count error flag wrong");

   property p_phase_read;
      (CE && RD && ADDR == `ADDR_PHASE_HOLD) |=>
         (RDATA[31:`PHASE_MSB+1] == 22'h000000) &&
         (RDATA[`PHASE_MSB:0] == $past(phase_hold));
   endproperty
   a_phase_read: assert property (p_phase_read)
      else $error("phase holding read wrong");

   property p_strobe_read;
      (CE && RD && (ADDR == `ADDR_FREQ_STROBE ||
                    ADDR == `ADDR_PHASE_STROBE))
         |=> (RDATA == 32'h00000000);
   endproperty
   a_strobe_read: assert property (p_strobe_read)
      else $error("strobe location returned data");

   property p_sync_load;
      (CE && sync_req && upd_en) |=>
         (ACTIVE_PHASE == $past(phase_hold)) &&
         (ACTIVE_FREQ == $past(freq_hold));
   endproperty
   a_sync_load: assert property (p_sync_load)
      else $error("carrier sync did not load both words");

   property p_hold_capture;
      wr_phase_hold |=> (phase_hold == $past(WDATA[`PHASE_MSB:0]));
   endproperty
   a_hold_capture: assert property (p_hold_capture)
      else $error("phase holding word not captured");

   property p_cfg_ctrl_fields;
      wr_filter_cfg |=> (FILTER_CFG.ext_sync_en == $past(WDATA[21]))
         && (FILTER_CFG.hb_bypass == $past(WDATA[20]))
         && (FILTER_CFG.fir_taps == $past(WDATA[7:0]));
   endproperty
   a_cfg_ctrl_fields: assert property (p_cfg_ctrl_fields)
      else $error("filter control fields not captured");

   property p_stage_ok;
      (CE && (FILTER_CFG.hb_bypass || FILTER_CFG.hb_stage_en != 5'h00))
         |=> !STATUS.stage_err;
   endproperty
   a_stage_ok: assert property (p_stage_ok)
      else $error("stage error flag set on valid setup");

   property p_deferred;
      (CE && upd_en && phase_pending) |=>
         (ACTIVE_PHASE == $past(phase_hold)) && !phase_pending;
   endproperty
   a_deferred: assert property (p_deferred)
      else $error("remembered phase load not applied");

   property p_filter_word_hold;
      !wr_filter_cfg |=> $stable(FILTER_CFG) && $stable(FIR_DECIMATION);
   endproperty
   a_filter_word_hold: assert property (p_filter_word_hold)
      else $error("filter word changed without a write");

   c_sync_load: cover property (
      CE && sync_req && upd_en ##1 ACTIVE_PHASE == $past(phase_hold));
   c_deferred: cover property (
      CE && phase_req && !upd_en ##[1:8] upd_en);
   c_filter_reset: cover property (FILTER_CTRL_RESET);
   c_dec16: cover property (FIR_DECIMATION == `DEC_FULL && CE);

endmodule : carrier_phase_filter_cfg
`default_nettype wire

// ==== verilog/transfer_latch.sv ====
// holding-to-active transfer with a remembered request
`timescale 1ns/1ps
`default_nettype none
module transfer_latch #(
   parameter int W = 10
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // transfer control
   input  wire logic [W-1:0] hold,
   input  wire logic         load_req,
   input  wire logic         upd_en,
   // active value
   output var  logic [W-1:0] active,
   output var  logic         pending
);

   generate
      if (W < 1) begin : g_bad_width
         $error("transfer_latch width must be at least one");
      end
   endgenerate

   logic fire;
   assign fire = ce && upd_en && (load_req || pending);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= '0;
      end else if (fire) begin
         active <= hold;
      end
   end

   // remembered until the next update cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (ce) begin
         if (fire) begin
            pending <= 1'b0;
         end else if (load_req) begin
            pending <= 1'b1;
         end
      end
   end

   property p_held_request;
      @(posedge clk) disable iff (!rst_n)
      (ce && load_req && !upd_en) |=> pending;
   endproperty
   a_held_request: assert property (p_held_request)
      else $error("request while idle was not remembered");

   property p_applied_on_enable;
      @(posedge clk) disable iff (!rst_n)
      (ce && upd_en && (load_req || pending))
         |=> (active == $past(hold)) && !pending;
   endproperty
   a_applied_on_enable: assert property (p_applied_on_enable)
      else $error("pending transfer not applied on update");

endmodule : transfer_latch
`default_nettype wire
